// File: pkg/eis_params.svh
`ifndef EIS_PARAMS_SVH
`define EIS_PARAMS_SVH

`define EIS_NUM_CHAN 8
`define EIS_NUM_SRC 12
`define EIS_ADDR_W 15
`define EIS_DATA_W 8

`define EIS_SUMMARY_OFF 12'hb00
`define EIS_CLKCFG_OFF 12'h100
`define EIS_IRQ_STAT_OFF 12'hf00
`define EIS_IRQ_MASK_OFF 12'hf01

`define EIS_SPARE_STAT_OFF 12'hb0c
`define EIS_DLC0_STAT_OFF 12'hb06
`define EIS_DLC1_STAT_OFF 12'hb16
`define EIS_DLC2_STAT_OFF 12'hb26
`define EIS_DLC3_STAT_OFF 12'hb10
`define EIS_DLC4_STAT_OFF 12'hb18
`define EIS_DLC5_STAT_OFF 12'hb28
`define EIS_SLIP_STAT_OFF 12'hb08
`define EIS_ALARM0_STAT_OFF 12'hb02
`define EIS_ALARM1_STAT_OFF 12'hb0e
`define EIS_ALARM2_STAT_OFF 12'hb40
`define EIS_FRAMER_STAT_OFF 12'hb04

`define EIS_SRC_SPARE 0
`define EIS_SRC_DLC 1
`define EIS_SRC_SLIP 7
`define EIS_SRC_ALARM 8
`define EIS_SRC_FRAMER 11

`define EIS_BIT_SPARE 7
`define EIS_BIT_UNUSED 6
`define EIS_BIT_CLK_LOSS 5
`define EIS_BIT_ONE_SEC 4
`define EIS_BIT_DLC 3
`define EIS_BIT_SLIP 2
`define EIS_BIT_ALARM 1
`define EIS_BIT_FRAMER 0

`define EIS_CLKCFG_EN_BIT 0
`define EIS_SUMMARY_RST 8'h00
`define EIS_REG_RST 8'h00
`define EIS_SRC_RST 12'h000

`endif

// File: pkg/eis_pkg.sv
`include "eis_params.svh"

package eis_pkg;
    typedef logic [`EIS_DATA_W-1:0] eis_byte_t;
    typedef logic [`EIS_ADDR_W-1:0] eis_addr_t;
    typedef logic [11:0] eis_off_t;
    typedef logic [2:0] eis_chan_t;
    typedef logic [`EIS_NUM_SRC-1:0] eis_src_vec_t;
endpackage : eis_pkg

// File: pkg/eis_src_if.sv
`timescale 1ns/1ps
`default_nettype none

interface eis_src_if;
    import eis_pkg::*;
    eis_src_vec_t ev;
    eis_src_vec_t rd_clr;
    logic clk_loss;
    logic clk_loss_en;
    logic one_sec;
    eis_byte_t summary;

    modport chan (
        input ev,
        input rd_clr,
        input clk_loss,
        input clk_loss_en,
        input one_sec,
        output summary
    );

    modport top (
        output ev,
        output rd_clr,
        output clk_loss,
        output clk_loss_en,
        output one_sec,
        input summary
    );
endinterface : eis_src_if

`default_nettype wire

// File: logic/eis_chan_summary.sv
`timescale 1ns/1ps
`default_nettype none
`include "eis_params.svh"

module eis_chan_summary
    import eis_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    eis_src_if.chan src
);
    eis_src_vec_t pending;

    // A source event in the same cycle as the clearing read keeps the flag set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= `EIS_SRC_RST;
        end else begin
            pending <= (pending & ~src.rd_clr) | src.ev;
        end
    end

    always_comb begin
        src.summary = `EIS_SUMMARY_RST;
        src.summary[`EIS_BIT_SPARE] = pending[`EIS_SRC_SPARE];
        src.summary[`EIS_BIT_UNUSED] = 1'b0;
        src.summary[`EIS_BIT_CLK_LOSS] = src.clk_loss & src.clk_loss_en;
        src.summary[`EIS_BIT_ONE_SEC] = src.one_sec;
        src.summary[`EIS_BIT_DLC] = |pending[`EIS_SRC_DLC +: 6];
        src.summary[`EIS_BIT_SLIP] = pending[`EIS_SRC_SLIP];
        src.summary[`EIS_BIT_ALARM] = |pending[`EIS_SRC_ALARM +: 3];
        src.summary[`EIS_BIT_FRAMER] = pending[`EIS_SRC_FRAMER];
    end
endmodule : eis_chan_summary

`default_nettype wire

// File: logic/eis_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eis_params.svh"

module eis_top
    import eis_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`EIS_ADDR_W-1:0] addr,
    input wire logic [`EIS_DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [`EIS_DATA_W-1:0] rd_data,
    input wire logic [`EIS_NUM_CHAN-1:0] spare_bit_block_event,
    input wire logic [`EIS_NUM_CHAN-1:0][5:0] dlc_event,
    input wire logic [`EIS_NUM_CHAN-1:0] slip_event,
    input wire logic [`EIS_NUM_CHAN-1:0][2:0] alarm_event,
    input wire logic [`EIS_NUM_CHAN-1:0] framer_event,
    input wire logic [`EIS_NUM_CHAN-1:0] recovered_clock_loss_pending,
    input wire logic [`EIS_NUM_CHAN-1:0] one_second_event_pending,
    output logic irq
);
    // True when the access addresses the given local offset of the given channel.
    function automatic logic reg_hit(input eis_addr_t a, input eis_chan_t ch,
                                     input eis_off_t off);
        reg_hit = (a[14:12] == ch) && (a[11:0] == off);
    endfunction : reg_hit

    // Maps a source status offset to the pending flag that a read of it retires.
    function automatic eis_src_vec_t src_clr_mask(input eis_off_t off);
        src_clr_mask = `EIS_SRC_RST;
        unique case (off)
            `EIS_SPARE_STAT_OFF: src_clr_mask[`EIS_SRC_SPARE] = 1'b1;
            `EIS_DLC0_STAT_OFF: src_clr_mask[`EIS_SRC_DLC + 0] = 1'b1;
            `EIS_DLC1_STAT_OFF: src_clr_mask[`EIS_SRC_DLC + 1] = 1'b1;
            `EIS_DLC2_STAT_OFF: src_clr_mask[`EIS_SRC_DLC + 2] = 1'b1;
            `EIS_DLC3_STAT_OFF: src_clr_mask[`EIS_SRC_DLC + 3] = 1'b1;
            `EIS_DLC4_STAT_OFF: src_clr_mask[`EIS_SRC_DLC + 4] = 1'b1;
            `EIS_DLC5_STAT_OFF: src_clr_mask[`EIS_SRC_DLC + 5] = 1'b1;
            `EIS_SLIP_STAT_OFF: src_clr_mask[`EIS_SRC_SLIP] = 1'b1;
            `EIS_ALARM0_STAT_OFF: src_clr_mask[`EIS_SRC_ALARM + 0] = 1'b1;
            `EIS_ALARM1_STAT_OFF: src_clr_mask[`EIS_SRC_ALARM + 1] = 1'b1;
            `EIS_ALARM2_STAT_OFF: src_clr_mask[`EIS_SRC_ALARM + 2] = 1'b1;
            `EIS_FRAMER_STAT_OFF: src_clr_mask[`EIS_SRC_FRAMER] = 1'b1;
            default: src_clr_mask = `EIS_SRC_RST;
        endcase
    endfunction : src_clr_mask

    eis_byte_t summary [`EIS_NUM_CHAN];
    eis_byte_t summary_q [`EIS_NUM_CHAN];
    eis_byte_t irq_stat [`EIS_NUM_CHAN];
    eis_byte_t irq_mask [`EIS_NUM_CHAN];
    logic [`EIS_NUM_CHAN-1:0] clk_loss_en;
    logic [`EIS_NUM_CHAN-1:0] chan_irq;
    eis_chan_t acc_chan;
    eis_off_t acc_off;
    logic next_irq;
    eis_byte_t next_rd_data;

    assign acc_chan = addr[14:12];
    assign acc_off = addr[11:0];

    genvar ch;
    generate
        for (ch = 0; ch < `EIS_NUM_CHAN; ch++) begin : g_chan
            eis_src_if src ();
            eis_byte_t stat_w1c;

            assign src.ev = {framer_event[ch], alarm_event[ch], slip_event[ch],
                             dlc_event[ch], spare_bit_block_event[ch]};
            // Only a read retires a source flag; a write to the same offset does not.
            assign src.rd_clr = (rd_en && acc_chan == eis_chan_t'(ch))
                                ? src_clr_mask(acc_off) : `EIS_SRC_RST;
            assign src.clk_loss = recovered_clock_loss_pending[ch];
            assign src.clk_loss_en = clk_loss_en[ch];
            assign src.one_sec = one_second_event_pending[ch];
            assign summary[ch] = src.summary;

            eis_chan_summary u_summary (
                .clk(clk),
                .rst_n(rst_n),
                .src(src.chan)
            );

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    clk_loss_en[ch] <= 1'b0;
                end else if (wr_en && reg_hit(addr, eis_chan_t'(ch), `EIS_CLKCFG_OFF)) begin
                    clk_loss_en[ch] <= wr_data[`EIS_CLKCFG_EN_BIT];
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_mask[ch] <= `EIS_REG_RST;
                end else if (wr_en && reg_hit(addr, eis_chan_t'(ch), `EIS_IRQ_MASK_OFF)) begin
                    irq_mask[ch] <= wr_data;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    summary_q[ch] <= `EIS_SUMMARY_RST;
                end else begin
                    summary_q[ch] <= summary[ch];
                end
            end

            assign stat_w1c = (wr_en && reg_hit(addr, eis_chan_t'(ch), `EIS_IRQ_STAT_OFF))
                              ? wr_data : `EIS_REG_RST;

            // A rising summary bit wins over a write-one-to-clear in the same cycle.
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_stat[ch] <= `EIS_REG_RST;
                end else begin
                    irq_stat[ch] <= (irq_stat[ch] & ~stat_w1c) | (summary[ch] & ~summary_q[ch]);
                end
            end

            assign chan_irq[ch] = |(irq_stat[ch] & irq_mask[ch]);
        end
    endgenerate

    assign next_irq = |chan_irq;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // Writes to the summary offset fall through unused, so the register stays read-only.
    always_comb begin
        next_rd_data = `EIS_REG_RST;
        unique case (acc_off)
            `EIS_SUMMARY_OFF: next_rd_data = summary[acc_chan];
            `EIS_CLKCFG_OFF: next_rd_data[`EIS_CLKCFG_EN_BIT] = clk_loss_en[acc_chan];
            `EIS_IRQ_STAT_OFF: next_rd_data = irq_stat[acc_chan];
            `EIS_IRQ_MASK_OFF: next_rd_data = irq_mask[acc_chan];
            default: next_rd_data = `EIS_REG_RST;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe and are zero otherwise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `EIS_REG_RST;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= `EIS_REG_RST;
        end
    end
endmodule : eis_top

`default_nettype wire

// File: logic/eis_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: dv/eis_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "eis_params.svh"
module eis_top_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`EIS_ADDR_W-1:0] addr,
    input wire logic [`EIS_DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [`EIS_DATA_W-1:0] rd_data,
    input wire logic [`EIS_NUM_CHAN-1:0] spare_bit_block_event,
    input wire logic [`EIS_NUM_CHAN-1:0][5:0] dlc_event,
    input wire logic [`EIS_NUM_CHAN-1:0] slip_event,
    input wire logic [`EIS_NUM_CHAN-1:0][2:0] alarm_event,
    input wire logic [`EIS_NUM_CHAN-1:0] framer_event,
    input wire logic [`EIS_NUM_CHAN-1:0] recovered_clock_loss_pending,
    input wire logic [`EIS_NUM_CHAN-1:0] one_second_event_pending,
    input wire logic irq
);
    wire [2:0] ch = addr[14:12];
    wire sum_rd = rd_en && addr[11:0] == `EIS_SUMMARY_OFF;
    logic [4:0][7:0] q1, q2;
    // Only ports are visible here, so the detection enable is shadowed from bus writes.
    logic [7:0] en_sh;
    // Events are delayed two cycles so a summary read can be tied to them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q1 <= '0;
            q2 <= '0;
            en_sh <= '0;
        end else begin
            q2 <= q1;
            if (wr_en && addr[11:0] == `EIS_CLKCFG_OFF) begin
                en_sh[ch] <= wr_data[`EIS_CLKCFG_EN_BIT];
            end
            q1[4] <= spare_bit_block_event;
            q1[2] <= slip_event;
            q1[0] <= framer_event;
            for (int i = 0; i < 8; i++) begin
                q1[3][i] <= |dlc_event[i];
                q1[1][i] <= |alarm_event[i];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_clr(logic [11:0] off, logic ev);
        rd_en && addr[11:0] == off && !ev;
    endsequence
    property p_set(logic ev, int b);
        sum_rd && !$past(rd_en) && ev |=> rd_data[b];
    endproperty
    property p_clr(logic [11:0] off, logic ev, int b);
        s_clr(off, ev) ##1 !ev ##1 (sum_rd && ch == $past(ch, 2)) |=> !rd_data[b];
    endproperty
    a_idle_read_zero: assert property (!rd_en |=> rd_data == 8'h00) else $error("rd_data not zero");
    a_unused_bit_low: assert property (!rd_data[6]) else $error("bit 6 set");
    a_clk_loss_gate: assert property (sum_rd && !recovered_clock_loss_pending[ch] |=> !rd_data[5]) else $error("bit 5 set");
    a_one_sec_follow: assert property (sum_rd |=> rd_data[4] == $past(one_second_event_pending[ch])) else $error("bit 4 wrong");
    a_spare_set: assert property (p_set(q2[4][ch], 7)) else $error("bit 7 not set");
    a_dlc_set: assert property (p_set(q2[3][ch], 3)) else $error("bit 3 not set");
    a_slip_set: assert property (p_set(q2[2][ch], 2)) else $error("bit 2 not set");
    a_alarm_set: assert property (p_set(q2[1][ch], 1)) else $error("bit 1 not set");
    a_framer_set: assert property (p_set(q2[0][ch], 0)) else $error("bit 0 not set");
    a_spare_clear: assert property (p_clr(12'hb0c, spare_bit_block_event[ch], 7)) else $error("bit 7 kept");
    a_slip_clear: assert property (p_clr(12'hb08, slip_event[ch], 2)) else $error("bit 2 kept");
    a_framer_clear: assert property (p_clr(12'hb04, framer_event[ch], 0)) else $error("bit 0 kept");
    a_clk_loss_off: assert property (sum_rd && !en_sh[ch] |=> !rd_data[5]) else $error("bit 5 set while off");
    a_clk_loss_on: assert property (sum_rd && en_sh[ch] |=> rd_data[5] == $past(recovered_clock_loss_pending[ch])) else $error("bit 5 wrong");
endmodule : eis_top_chk
`default_nettype wire

// File: dv/eis_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "eis_params.svh"
module eis_top_bench;
    import eis_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, irq;
    eis_addr_t addr = '0;
    eis_byte_t wr_data = '0, rd_data;
    logic [7:0] sp = '0, sl = '0, fr = '0, cl = '0, os = '0;
    logic [7:0][5:0] dl = '0;
    logic [7:0][2:0] al = '0;
    int error_cnt = 0, cmp_count = 0, seed = 3635;
    always #5 clk = ~clk;
    eis_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .spare_bit_block_event(sp), .dlc_event(dl),
        .slip_event(sl), .alarm_event(al), .framer_event(fr),
        .recovered_clock_loss_pending(cl), .one_second_event_pending(os), .irq(irq));
    function automatic eis_addr_t adr(int c, eis_off_t o);
        return {3'(c), o};
    endfunction : adr
    function automatic eis_byte_t exp_sum(int s);
        return 8'h01 << (s == 0 ? 7 : s == 1 ? 3 : s == 2 ? 2 : s == 3 ? 1 : 0);
    endfunction : exp_sum
    function automatic eis_off_t clr_off(int s, int i);
        eis_off_t d[6] = '{12'hb06, 12'hb16, 12'hb26, 12'hb10, 12'hb18, 12'hb28};
        eis_off_t a[3] = '{12'hb02, 12'hb0e, 12'hb40};
        return s == 0 ? 12'hb0c : s == 1 ? d[i] : s == 2 ? 12'hb08 : s == 3 ? a[i] : 12'hb04;
    endfunction : clr_off
    task automatic check(input string what, input eis_byte_t seen, input eis_byte_t exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input eis_addr_t a, input eis_byte_t d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rdc(input eis_addr_t a, input eis_byte_t exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check($sformatf("rd_data at %h", a), rd_data, exp);
    endtask : rdc
    task automatic pulse(input int s, input int c, input int i);
        @(posedge clk);
        case (s)
            0: sp[c] <= 1'b1;
            1: dl[c][i] <= 1'b1;
            2: sl[c] <= 1'b1;
            3: al[c][i] <= 1'b1;
            default: fr[c] <= 1'b1;
        endcase
        @(posedge clk);
        {sp, sl, fr, dl, al} <= '0;
    endtask : pulse
    task automatic irq_is(input eis_byte_t exp, input int wait_n);
        repeat (wait_n) @(posedge clk);
        #1 check("irq", {7'h00, irq}, exp);
    endtask : irq_is
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        int c, s, m;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (c = 0; c < 8; c++) begin
            rdc(adr(c, 12'hb00), 8'h00);
            wr(adr(c, 12'hb00), 8'($random(seed)));
            rdc(adr(c, 12'hb00), 8'h00);
        end
        rdc(adr(1, 12'h123), 8'h00);
        irq_is(8'h00, 0);
        $display("reset test done");
        // Split sources get two raisers so one clearing read must not drop the bit.
        for (int k = 0; k < 40; k++) begin
            c = $random(seed) & 7;
            s = ($random(seed) & 32'hff) % 5;
            m = s == 1 || s == 3;
            pulse(s, c, 0);
            if (m) pulse(s, c, s == 1 ? 5 : 2);
            rdc(adr(c, 12'hb00), exp_sum(s));
            rdc(adr(c ^ 1, 12'hb00), 8'h00);
            rdc(adr(c, clr_off(s, 0)), 8'h00);
            rdc(adr(c, 12'hb00), m ? exp_sum(s) : 8'h00);
            if (m) rdc(adr(c, clr_off(s, s == 1 ? 5 : 2)), 8'h00);
            if (m) rdc(adr(c, 12'hb00), 8'h00);
        end
        $display("source test done");
        @(posedge clk);
        cl <= 8'hff;
        os <= 8'h08;
        rdc(adr(3, 12'hb00), 8'h10);
        wr(adr(3, 12'h100), 8'h01);
        rdc(adr(3, 12'hb00), 8'h30);
        rdc(adr(2, 12'hb00), 8'h00);
        @(posedge clk);
        cl <= '0;
        os <= '0;
        rdc(adr(3, 12'hb00), 8'h00);
        $display("level test done");
        for (c = 0; c < 8; c++) wr(adr(c, 12'hf00), 8'hff);
        wr(adr(5, 12'hf01), 8'h04);
        pulse(0, 5, 0);
        irq_is(8'h00, 4);
        pulse(2, 5, 0);
        irq_is(8'h01, 4);
        rdc(adr(5, 12'hf00), 8'h84);
        rdc(adr(5, 12'hb08), 8'h00);
        wr(adr(5, 12'hf00), 8'h04);
        irq_is(8'h00, 2);
        $display("interrupt test done");
        rdc(adr(5, 12'hb00), 8'h80);
        rdc(adr(5, 12'hf00), 8'h80);
        // A clearing read in the same cycle as a new slip event must leave the flag set.
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= adr(6, 12'hb08);
        sl[6] <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        sl <= '0;
        rdc(adr(6, 12'hb00), 8'h04);
        wr(adr(6, 12'hb08), 8'hff);
        rdc(adr(6, 12'hb00), 8'h04);
        rdc(adr(6, 12'hb08), 8'h00);
        rdc(adr(6, 12'hb00), 8'h00);
        rdc(adr(3, 12'h100), 8'h01);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rdc(adr(5, 12'hb00), 8'h00);
        rdc(adr(5, 12'hf00), 8'h00);
        rdc(adr(5, 12'hf01), 8'h00);
        rdc(adr(3, 12'h100), 8'h00);
        irq_is(8'h00, 0);
        $display("corner test done");
        summarize();
    end
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
endmodule : eis_top_bench
bind eis_top eis_top_chk chk (.*);
`default_nettype wire
